// ==== logic/mdwl_defs.svh ====
// Constants for the module-disable write lock
`ifndef MDWL_DEFS_SVH
`define MDWL_DEFS_SVH
`define MDWL_DATA_W 32
`define MDWL_NUM_MD 4
`define MDWL_IDX_W 2
`define MDWL_LOCK_BIT 12
`define MDWL_ONE_WAY_BIT 28
`define MDWL_UNLOCK_KEY1 32'h1234_5678
`define MDWL_UNLOCK_KEY2 32'h9ABC_DEF0
`define MDWL_LOCK_RST 1'h0
`define MDWL_MD_RST 32'h0000_0000
`define MDWL_CFG_RST 32'h0000_0000
`endif

// ==== logic/mdwl_pkg.sv ====
// Types shared by the module-disable write lock
package mdwl_pkg;
  typedef enum logic [1:0] {
    TGT_KEY = 2'b00,
    TGT_CFG = 2'b01,
    TGT_MD = 2'b10,
    TGT_NONE = 2'b11
  } wr_target_t;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_KEY1 = 2'b01,
    UNL_OPEN = 2'b10
  } unlock_state_t;
endpackage

// ==== logic/unlock_key_seq.sv ====
// Two-word unlock key detector that opens a window until the next config or key write
`include "mdwl_defs.svh"
module unlock_key_seq (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic key_wr,
  input wire logic [`MDWL_DATA_W-1:0] key_data,
  input wire logic cfg_wr,
  input wire logic inhibit,
  output logic window_open
);
  import mdwl_pkg::*;

  unlock_state_t state_reg;
  unlock_state_t state_next;
  logic window_reg;
  logic window_next;

  always_comb begin
    state_next = state_reg;
    if (ce) begin
      if (inhibit) begin
        state_next = UNL_IDLE;
      end else begin
        unique case (state_reg)
          UNL_IDLE: begin
            if (key_wr && key_data == `MDWL_UNLOCK_KEY1) begin
              state_next = UNL_KEY1;
            end
          end
          UNL_KEY1: begin
            // Any stray key write aborts, so keys must be back to back
            if (key_wr) begin
              state_next = (key_data == `MDWL_UNLOCK_KEY2) ? UNL_OPEN : UNL_IDLE;
            end
          end
          UNL_OPEN: begin
            if (cfg_wr || key_wr) begin
              state_next = UNL_IDLE;
            end
          end
          default: state_next = UNL_IDLE;
        endcase
      end
    end
    // Registered copy so the window reaches the top straight from a flop
    window_next = (state_next == UNL_OPEN);
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= UNL_IDLE;
      window_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      window_reg <= window_next;
    end
  end

  assign window_open = window_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_key_pair_opens: assert property (
    ce && !inhibit && state_reg == UNL_KEY1 && key_wr && key_data == `MDWL_UNLOCK_KEY2
    |=> window_open)
    else $error("Correct key pair did not open the window");
  a_inhibit_closes: assert property (
    ce && inhibit |=> !window_open)
    else $error("Window open while unlock is inhibited");
  c_window_opened: cover property (ce && !window_open ##1 window_open);
endmodule

// ==== logic/module_disable_write_lock.sv ====
// Write lock for the module-disable registers and its control bit
// Operation
// - Locked writes to module_disable_regs complete normally but change nothing.
// - Lock sits at config_control_reg bit 12; one blocks, zero permits writes.
// - The lock bit changes only after a valid unlock sequence.
// - With lock_one_way_only set, a set lock cannot be cleared.
// - Under one-way mode with lock set, unlock never runs; writes do nothing.
// - Under one-way mode, only device reset clears a set lock.
`include "mdwl_defs.svh"
module module_disable_write_lock (
  input wire logic clk,
  input wire logic resetn,
  input wire logic ce,
  input wire logic wr_valid,
  input wire mdwl_pkg::wr_target_t wr_target,
  input wire logic [`MDWL_IDX_W-1:0] wr_index,
  input wire logic [`MDWL_DATA_W-1:0] wr_data,
  input wire logic [`MDWL_DATA_W-1:0] device_config_word_three,
  output logic wr_done,
  output logic disable_reg_lock,
  output logic [`MDWL_DATA_W-1:0] config_control_reg,
  output logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] module_disable_regs,
  output logic unlock_window_open
);
  import mdwl_pkg::*;

  logic lock_one_way_only;
  logic key_wr;
  logic cfg_wr;
  logic md_wr;
  logic sticky;
  logic window;

  // Accepted write aimed at one target; other targets still complete
  function automatic logic write_to(
    input logic en,
    input logic valid,
    input wr_target_t target,
    input wr_target_t wanted
  );
    return en && valid && target == wanted;
  endfunction

  // Array with one entry blanked, to compare entries a write must not touch
  function automatic logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] md_without(
    input logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] regs,
    input logic [`MDWL_IDX_W-1:0] idx
  );
    logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] masked;
    masked = regs;
    masked[idx] = `MDWL_MD_RST;
    return masked;
  endfunction

  assign lock_one_way_only = device_config_word_three[`MDWL_ONE_WAY_BIT];
  assign key_wr = write_to(ce, wr_valid, wr_target, TGT_KEY);
  assign cfg_wr = write_to(ce, wr_valid, wr_target, TGT_CFG);
  assign md_wr = write_to(ce, wr_valid, wr_target, TGT_MD);
  // Sticky lock: one-way fuse set and lock already taken
  // Limitation: if the fuse input drops, unlock can change the lock again
  assign sticky = lock_one_way_only && disable_reg_lock;

  unlock_key_seq u_keys (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .key_wr(key_wr),
    .key_data(wr_data),
    .cfg_wr(cfg_wr),
    .inhibit(sticky),
    .window_open(window)
  );
  assign unlock_window_open = window;

  // Lock bit and its view in the control register
  logic lock_reg;
  logic lock_next;
  logic [`MDWL_DATA_W-1:0] cfg_reg;
  logic [`MDWL_DATA_W-1:0] cfg_next;

  always_comb begin
    lock_next = lock_reg;
    if (cfg_wr && window && !sticky) begin
      lock_next = wr_data[`MDWL_LOCK_BIT];
    end
    if (sticky) begin
      lock_next = 1'b1;
    end
    // View built from the next lock so it never lags the lock by a cycle
    cfg_next = `MDWL_CFG_RST;
    cfg_next[`MDWL_LOCK_BIT] = lock_next;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lock_reg <= `MDWL_LOCK_RST;
      cfg_reg <= `MDWL_CFG_RST;
    end else begin
      lock_reg <= lock_next;
      cfg_reg <= cfg_next;
    end
  end

  assign disable_reg_lock = lock_reg;
  assign config_control_reg = cfg_reg;

  // Module-disable storage
  logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] md_reg;
  logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] md_next;

  always_comb begin
    md_next = md_reg;
    // Locked writes are simply dropped; the bus still sees completion
    if (md_wr && !lock_reg) begin
      md_next[wr_index] = wr_data;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < `MDWL_NUM_MD; i++) begin
        md_reg[i] <= `MDWL_MD_RST;
      end
    end else begin
      md_reg <= md_next;
    end
  end

  assign module_disable_regs = md_reg;

  // Completion pulse for every accepted write, locked or not
  logic done_reg;
  logic done_next;

  always_comb begin
    done_next = done_reg;
    if (ce) begin
      done_next = wr_valid;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= done_next;
    end
  end

  assign wr_done = done_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_locked_md_hold: assert property (
    md_wr && disable_reg_lock |=> $stable(module_disable_regs) && wr_done)
    else $error("Locked module-disable write changed contents");
  a_unlocked_md_write: assert property (
    md_wr && !disable_reg_lock
    |=> module_disable_regs[$past(wr_index)] == $past(wr_data))
    else $error("Unlocked module-disable write not stored");
  a_lock_bit_view: assert property (
    config_control_reg[`MDWL_LOCK_BIT] == disable_reg_lock)
    else $error("Lock bit not shown at bit 12");
  a_no_key_change: assert property (
    ce && !window && !sticky |=> $stable(disable_reg_lock))
    else $error("Lock bit changed without unlock");
  a_window_grants: assert property (
    cfg_wr && window && !sticky |=> disable_reg_lock == $past(wr_data[`MDWL_LOCK_BIT])
      && !unlock_window_open)
    else $error("Unlocked lock-bit write not honoured once");
  a_one_way_sticky: assert property (
    sticky |=> disable_reg_lock [*2])
    else $error("One-way lock was cleared");
  a_one_way_no_unlock: assert property (
    sticky ##1 lock_one_way_only |-> !unlock_window_open)
    else $error("Unlock ran under one-way lock");
  a_reset_only_clear: assert property (
    sticky && cfg_wr && !wr_data[`MDWL_LOCK_BIT] |=> disable_reg_lock)
    else $error("Sticky lock cleared by write");
  a_write_done: assert property (
    ce && wr_valid |=> wr_done)
    else $error("Write did not complete");
  a_done_single: assert property (
    ce && !wr_valid |=> !wr_done)
    else $error("Completion shown without a write");

  // A stalled enable must hold every visible bit of state
  a_stall_freezes: assert property (
    !ce
    |=> $stable(disable_reg_lock) && $stable(module_disable_regs)
      && $stable(wr_done) && $stable(config_control_reg)
      && $stable(unlock_window_open))
    else $error("State moved while clock enable was low");
  a_other_target_inert: assert property (
    ce && wr_valid && wr_target == TGT_NONE
    |=> $stable(module_disable_regs) && $stable(disable_reg_lock) && wr_done)
    else $error("Write to no target changed state or did not complete");
  a_md_others_hold: assert property (
    md_wr && !disable_reg_lock
    |=> md_without(module_disable_regs, $past(wr_index))
      == md_without($past(module_disable_regs), $past(wr_index)))
    else $error("Module-disable write touched another register");
  a_cfg_other_bits: assert property (
    (config_control_reg & ~(32'h0000_0001 << `MDWL_LOCK_BIT)) == 32'h0000_0000)
    else $error("Control register shows bits other than the lock");

  // The window must come only from the key pair and close on any key write
  a_window_needs_keys: assert property (
    $rose(unlock_window_open) |-> $past(key_wr && wr_data == `MDWL_UNLOCK_KEY2))
    else $error("Unlock window opened without the second key");
  a_key_write_closes: assert property (
    key_wr && unlock_window_open |=> !unlock_window_open)
    else $error("Key write left the unlock window open");

  c_lock_set: cover property (!disable_reg_lock ##1 disable_reg_lock);
  c_lock_cleared: cover property (disable_reg_lock ##1 !disable_reg_lock);
  c_locked_write: cover property (md_wr && disable_reg_lock);
  c_sticky_attempt: cover property (sticky && key_wr);
  c_stalled_write: cover property (!ce && wr_valid);
endmodule

// ==== verif/tb.sv ====
// Self-checking testbench for the module-disable write lock
`include "mdwl_defs.svh"
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  import mdwl_pkg::*;
  localparam logic [31:0] LOCK1 = 32'h0000_1000;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic ce = 1'b1;
  logic wr_valid = 1'b0;
  wr_target_t wr_target = TGT_NONE;
  logic [`MDWL_IDX_W-1:0] wr_index = '0;
  logic [`MDWL_DATA_W-1:0] wr_data = '0;
  logic [`MDWL_DATA_W-1:0] device_config_word_three = '0;
  logic wr_done;
  logic disable_reg_lock;
  logic [`MDWL_DATA_W-1:0] config_control_reg;
  logic [`MDWL_NUM_MD-1:0][`MDWL_DATA_W-1:0] module_disable_regs;
  logic unlock_window_open;
  int n_errors = 0;
  int cmp_count = 0;
  int cycles = 0;
  always #2.5 clk = ~clk;
  module_disable_write_lock dut (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .wr_valid(wr_valid),
    .wr_target(wr_target),
    .wr_index(wr_index),
    .wr_data(wr_data),
    .device_config_word_three(device_config_word_three),
    .wr_done(wr_done),
    .disable_reg_lock(disable_reg_lock),
    .config_control_reg(config_control_reg),
    .module_disable_regs(module_disable_regs),
    .unlock_window_open(unlock_window_open)
  );
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Locked or ignored writes must still complete
  task automatic wr(wr_target_t t, logic [31:0] d, logic [1:0] i = 2'h0);
    @(posedge clk);
    #1;
    wr_valid = 1'b1;
    wr_target = t;
    wr_data = d;
    wr_index = i;
    @(posedge clk);
    #1;
    wr_valid = 1'b0;
    check("wr_done", wr_done, 32'h1);
  endtask
  task automatic unlock();
    wr(TGT_KEY, `MDWL_UNLOCK_KEY1);
    wr(TGT_KEY, `MDWL_UNLOCK_KEY2);
  endtask
  task automatic do_reset(int n);
    resetn = 1'b0;
    repeat (n) @(posedge clk);
    #1;
    resetn = 1'b1;
  endtask
  task automatic t_open_and_lock();
    wr(TGT_MD, 32'hA5A5_0001, 2'h1);
    check("md1", module_disable_regs[1], 32'hA5A5_0001);
    wr(TGT_CFG, LOCK1);
    check("lock", disable_reg_lock, 32'h0);
    wr(TGT_KEY, `MDWL_UNLOCK_KEY1);
    wr(TGT_KEY, 32'h0000_0000);
    check("win", unlock_window_open, 32'h0);
    unlock();
    check("win", unlock_window_open, 32'h1);
    wr(TGT_CFG, LOCK1);
    check("lock", disable_reg_lock, 32'h1);
    check("cfg", config_control_reg, LOCK1);
    check("win", unlock_window_open, 32'h0);
    wr(TGT_MD, 32'h0000_BEEF, 2'h1);
    check("md1", module_disable_regs[1], 32'hA5A5_0001);
  endtask
  task automatic t_clear_lock();
    unlock();
    wr(TGT_CFG, 32'h0000_0000);
    check("lock", disable_reg_lock, 32'h0);
    wr(TGT_MD, 32'h0000_0033, 2'h3);
    check("md3", module_disable_regs[3], 32'h0000_0033);
  endtask
  // A write held while the enable is low must wait, then land once
  task automatic t_ce_hold();
    @(posedge clk);
    #1;
    ce = 1'b0;
    wr_valid = 1'b1;
    wr_target = TGT_MD;
    wr_index = 2'h0;
    wr_data = 32'h0000_0066;
    repeat (2) @(posedge clk);
    #1;
    check("md0", module_disable_regs[0], 32'h0000_0000);
    check("done", wr_done, 32'h0);
    ce = 1'b1;
    @(posedge clk);
    #1;
    wr_valid = 1'b0;
    check("md0", module_disable_regs[0], 32'h0000_0066);
    check("done", wr_done, 32'h1);
  endtask
  // Writes to no target keep the window; a key write closes it
  task automatic t_other_writes();
    unlock();
    wr(TGT_NONE, LOCK1);
    check("lock", disable_reg_lock, 32'h0);
    check("win", unlock_window_open, 32'h1);
    wr(TGT_KEY, `MDWL_UNLOCK_KEY1);
    check("win", unlock_window_open, 32'h0);
    wr(TGT_CFG, LOCK1);
    check("lock", disable_reg_lock, 32'h0);
    check("cfg", config_control_reg, 32'h0000_0000);
  endtask
  // Sticky lock survives unlock attempts until reset
  task automatic t_one_way();
    unlock();
    wr(TGT_CFG, LOCK1);
    device_config_word_three = 32'h1000_0000;
    unlock();
    check("win", unlock_window_open, 32'h0);
    wr(TGT_CFG, 32'h0000_0000);
    check("lock", disable_reg_lock, 32'h1);
    wr(TGT_MD, 32'h0000_0044, 2'h3);
    check("md3", module_disable_regs[3], 32'h0000_0033);
    do_reset(3);
    check("lock", disable_reg_lock, 32'h0);
    check("done", wr_done, 32'h0);
    check("win", unlock_window_open, 32'h0);
    wr(TGT_MD, 32'h0000_0055, 2'h2);
    check("md2", module_disable_regs[2], 32'h0000_0055);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      print_verdict();
    end
  end
  initial begin
    do_reset(20);
    t_open_and_lock();
    t_clear_lock();
    t_one_way();
    t_ce_hold();
    t_other_writes();
    print_verdict();
  end
endmodule
